// ### hswh_top.sv
`timescale 1ns/1ns
// Operation
// - device finishes command, responds, drops indication, sleeps again
// - retained standby: responses only, no unsolicited data to host
// - retained standby keeps memory and operating state across sleep
// - non-retained standby: device sends no unsolicited data
// - auto schedule accepted only associated and before power-save entry
// - receive latency of zero is taken as two seconds
// - receive latency of two seconds or less refuses the session
// - scheduled mode: indication high each wake, low after service period
module hswh_top
  import hswh_pkg::*;
(
  // ahb-lite
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata_ff,
  output logic             hreadyout_ff,
  output logic             hresp_ff,
  // handshake pins
  input  wire logic        lp_wake_request_pin,
  input  wire logic        ulp_wake_request_pin,
  output logic             wake_indication_pin_a_ff,
  output logic             wake_indication_pin_b_ff,
  // device-to-host response strobe
  output logic             resp_valid_ff,
  output logic [31:0]      resp_data_ff
);

  // bus address phase capture
  logic        wr_pend_ff,  nxt_wr_pend;
  logic        rd_pend_ff,  nxt_rd_pend;
  logic [7:0]  addr_ff,     nxt_addr;

  // control and state
  hswh_mode_type  mode_ff,   nxt_mode;
  hswh_state_type state_ff,  nxt_state;
  logic        ulp_sel_ff,   nxt_ulp_sel;
  logic        assoc_ff,     nxt_assoc;
  logic        aps_ff,       nxt_aps;
  logic        cmd_rdy_ff,   nxt_cmd_rdy;
  logic        rsp_pend_ff,  nxt_rsp_pend;
  logic [31:0] rsp_word_ff,  nxt_rsp_word;
  logic        sched_ok_ff,  nxt_sched_ok;
  logic        sched_err_ff, nxt_sched_err;
  logic        nego_ff,      nxt_nego;
  logic [31:0] lat_ff,       nxt_lat;
  logic [15:0] tput_ff,      nxt_tput;
  logic [15:0] dev_tput_ff,  nxt_dev_tput;
  logic [15:0] svc_cnt_ff,   nxt_svc_cnt;
  logic        req_s1_ff,    req_s2_ff;
  logic        nxt_ind;
  logic        nxt_resp_valid;
  logic [31:0] nxt_resp_data;
  logic [31:0] nxt_rdata;
  logic [HSWH_CMD_AW-1:0] cmd_wp_ff, nxt_cmd_wp;

  logic        req_raw;
  logic        wr_go;
  logic [31:0] ram_rd;
  logic [31:0] eff_lat;

  assign req_raw = ulp_sel_ff ? ulp_wake_request_pin : lp_wake_request_pin;
  assign wr_go   = wr_pend_ff;

  // command store survives sleep periods
  hswh_ram u_ram (
    .hclk    (hclk),
    .wr_en   (wr_go && addr_ff == HSWH_CMD_OFS),
    .wr_addr (cmd_wp_ff),
    .wr_data (hwdata),
    .rd_addr (cmd_wp_ff - 2'h1),
    .rd_data_ff (ram_rd)
  );

  always_comb begin
    eff_lat = (hwdata == 32'h0) ? HSWH_LAT_DEFAULT_MS : hwdata;
  end

  always_comb begin
    nxt_wr_pend   = 1'b0;
    nxt_rd_pend   = 1'b0;
    nxt_addr      = addr_ff;
    nxt_mode      = mode_ff;
    nxt_state     = state_ff;
    nxt_ulp_sel   = ulp_sel_ff;
    nxt_assoc     = assoc_ff;
    nxt_aps       = aps_ff;
    nxt_cmd_rdy   = cmd_rdy_ff;
    nxt_rsp_pend  = rsp_pend_ff;
    nxt_rsp_word  = rsp_word_ff;
    nxt_sched_ok  = sched_ok_ff;
    nxt_sched_err = sched_err_ff;
    nxt_nego      = 1'b0;
    nxt_lat       = lat_ff;
    nxt_tput      = tput_ff;
    nxt_dev_tput  = dev_tput_ff;
    nxt_svc_cnt   = svc_cnt_ff;
    nxt_cmd_wp    = cmd_wp_ff;
    nxt_resp_valid = 1'b0;
    nxt_resp_data = resp_data_ff;
    nxt_rdata     = hrdata_ff;
    if (hsel && hready && htrans[1]) begin
      nxt_wr_pend = hwrite;
      nxt_rd_pend = !hwrite;
      nxt_addr    = haddr[7:0];
    end
    if (rd_pend_ff) begin
      unique case (addr_ff)
        HSWH_CTRL_OFS:   nxt_rdata = {26'h0, 1'b0, aps_ff, assoc_ff, ulp_sel_ff, mode_ff};
        HSWH_STATUS_OFS: nxt_rdata = {22'h0, req_s2_ff, nego_ff, sched_err_ff, sched_ok_ff,
                                      rsp_pend_ff, cmd_rdy_ff, 1'b0, state_ff};
        HSWH_CMD_OFS:    nxt_rdata = ram_rd;
        HSWH_RESP_OFS:   nxt_rdata = rsp_word_ff;
        HSWH_LAT_OFS:    nxt_rdata = lat_ff;
        HSWH_TPUT_OFS:   nxt_rdata = {dev_tput_ff, tput_ff};
        default:         nxt_rdata = 32'h0;
      endcase
    end
    if (wr_go) begin
      unique case (addr_ff)
        HSWH_CTRL_OFS: begin
          nxt_mode    = hswh_mode_type'(hwdata[HSWH_CTRL_MODE_LSB +: 2]);
          nxt_ulp_sel = hwdata[HSWH_CTRL_ULP_BIT];
          nxt_assoc   = hwdata[HSWH_CTRL_ASSOC];
          nxt_aps     = hwdata[HSWH_CTRL_APS];
        end
        HSWH_STATUS_OFS: begin
          nxt_sched_ok  = sched_ok_ff  & ~hwdata[HSWH_ST_SCHED_OK];
          nxt_sched_err = sched_err_ff & ~hwdata[HSWH_ST_SCHED_ERR];
        end
        HSWH_CMD_OFS: begin
          nxt_cmd_wp  = cmd_wp_ff + 2'h1;
          nxt_cmd_rdy = 1'b1;
        end
        HSWH_RESP_OFS: begin
          nxt_rsp_word = hwdata;
          nxt_rsp_pend = 1'b1;
        end
        HSWH_LAT_OFS:  nxt_lat = eff_lat;
        HSWH_TPUT_OFS: begin
          nxt_tput     = hwdata[15:0];
          nxt_dev_tput = hwdata[31:16];
        end
        HSWH_SCHED_OFS: begin
          if (hwdata[HSWH_SCHED_EN_BIT]) begin
            if (!assoc_ff || aps_ff || lat_ff <= HSWH_LAT_MIN_MS) begin
              nxt_sched_err = 1'b1;
            end else begin
              nxt_sched_ok = 1'b1;
              nxt_nego     = 1'b1;
            end
          end else begin
            nxt_sched_ok = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // responses leave only while a command is being served
    if (rsp_pend_ff && (state_ff == HSWH_ST_SERVE || state_ff == HSWH_ST_RELEASE ||
        state_ff == HSWH_ST_ACTIVE || state_ff == HSWH_ST_SVCPER)
        && cmd_rdy_ff) begin
      nxt_resp_valid = 1'b1;
      nxt_resp_data  = rsp_word_ff;
      nxt_rsp_pend   = 1'b0;
      nxt_cmd_rdy    = 1'b0;
    end
    unique case (state_ff)
      HSWH_ST_SLEEP: begin
        if (mode_ff == HSWH_MODE_ACTIVE) nxt_state = HSWH_ST_ACTIVE;
        else if (mode_ff == HSWH_MODE_SCHED) begin
          if (wr_go && addr_ff == HSWH_CTRL_OFS && hwdata[HSWH_CTRL_WAKE_BIT]) begin
            nxt_state   = HSWH_ST_SVCPER;
            nxt_svc_cnt = 16'(HSWH_SVC_CYCLES);
          end
        end else if (req_s2_ff) nxt_state = HSWH_ST_AWAKE;
      end
      HSWH_ST_AWAKE:
        if (cmd_rdy_ff) nxt_state = HSWH_ST_SERVE;
        else if (!req_s2_ff) nxt_state = HSWH_ST_RELEASE;
      HSWH_ST_SERVE:
        if (!req_s2_ff) nxt_state = HSWH_ST_RELEASE;
      HSWH_ST_RELEASE:
        if (!cmd_rdy_ff && !rsp_pend_ff) nxt_state = HSWH_ST_SLEEP;
      HSWH_ST_SVCPER: begin
        if (svc_cnt_ff == 16'h0) nxt_state = HSWH_ST_SLEEP;
        else nxt_svc_cnt = svc_cnt_ff - 16'h1;
      end
      HSWH_ST_ACTIVE:
        if (mode_ff != HSWH_MODE_ACTIVE) nxt_state = HSWH_ST_SLEEP;
      default: nxt_state = HSWH_ST_SLEEP;
    endcase
    nxt_ind = (nxt_state != HSWH_ST_SLEEP) && (nxt_state != HSWH_ST_RELEASE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      addr_ff      <= 8'h0;
      mode_ff      <= HSWH_MODE_ACTIVE;
      state_ff     <= HSWH_ST_SLEEP;
      ulp_sel_ff   <= 1'b0;
      assoc_ff     <= 1'b0;
      aps_ff       <= 1'b0;
      cmd_rdy_ff   <= 1'b0;
      rsp_pend_ff  <= 1'b0;
      rsp_word_ff  <= 32'h0;
      sched_ok_ff  <= 1'b0;
      sched_err_ff <= 1'b0;
      nego_ff      <= 1'b0;
      lat_ff       <= HSWH_LAT_DEFAULT_MS;
      tput_ff      <= 16'h0;
      dev_tput_ff  <= 16'h0;
      svc_cnt_ff   <= 16'h0;
      cmd_wp_ff    <= '0;
      req_s1_ff    <= 1'b0;
      req_s2_ff    <= 1'b0;
      hrdata_ff    <= 32'h0;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      wake_indication_pin_a_ff <= 1'b0;
      wake_indication_pin_b_ff <= 1'b0;
      resp_valid_ff <= 1'b0;
      resp_data_ff  <= 32'h0;
    end else begin
      wr_pend_ff   <= nxt_wr_pend;
      rd_pend_ff   <= nxt_rd_pend;
      addr_ff      <= nxt_addr;
      mode_ff      <= nxt_mode;
      state_ff     <= nxt_state;
      ulp_sel_ff   <= nxt_ulp_sel;
      assoc_ff     <= nxt_assoc;
      aps_ff       <= nxt_aps;
      cmd_rdy_ff   <= nxt_cmd_rdy;
      rsp_pend_ff  <= nxt_rsp_pend;
      rsp_word_ff  <= nxt_rsp_word;
      sched_ok_ff  <= nxt_sched_ok;
      sched_err_ff <= nxt_sched_err;
      nego_ff      <= nxt_nego;
      lat_ff       <= nxt_lat;
      tput_ff      <= nxt_tput;
      dev_tput_ff  <= nxt_dev_tput;
      svc_cnt_ff   <= nxt_svc_cnt;
      cmd_wp_ff    <= nxt_cmd_wp;
      req_s1_ff    <= req_raw;
      req_s2_ff    <= req_s1_ff;
      hrdata_ff    <= nxt_rdata;
      // one wait state per read so the registered read data stands when ready rises
      hreadyout_ff <= !nxt_rd_pend;
      hresp_ff     <= 1'b0;
      wake_indication_pin_a_ff <= nxt_ind;
      wake_indication_pin_b_ff <= nxt_ind;
      resp_valid_ff <= nxt_resp_valid;
      resp_data_ff  <= nxt_resp_data;
    end
  end

endmodule : hswh_top

// ### hswh_pkg.sv
package hswh_pkg;

  // register byte offsets
  localparam logic [7:0] HSWH_CTRL_OFS   = 8'h00;
  localparam logic [7:0] HSWH_STATUS_OFS = 8'h04;
  localparam logic [7:0] HSWH_CMD_OFS    = 8'h08;
  localparam logic [7:0] HSWH_RESP_OFS   = 8'h0c;
  localparam logic [7:0] HSWH_SCHED_OFS  = 8'h10;
  localparam logic [7:0] HSWH_LAT_OFS    = 8'h14;
  localparam logic [7:0] HSWH_TPUT_OFS   = 8'h18;
  localparam logic [7:0] HSWH_SVC_OFS    = 8'h1c;

  // ctrl fields
  localparam int HSWH_CTRL_MODE_LSB = 0;   // 2 bits
  localparam int HSWH_CTRL_ULP_BIT  = 2;   // select ultra-low-power request pin
  localparam int HSWH_CTRL_ASSOC    = 3;   // associated
  localparam int HSWH_CTRL_APS      = 4;   // associated power save entered
  localparam int HSWH_CTRL_WAKE_BIT = 5;   // scheduled wake tick (write pulse)

  // schedule command fields
  localparam int HSWH_SCHED_EN_BIT = 0;

  // status fields
  localparam int HSWH_ST_STATE_LSB = 0;    // 3 bits
  localparam int HSWH_ST_CMD_RDY   = 4;
  localparam int HSWH_ST_RSP_PEND  = 5;
  localparam int HSWH_ST_SCHED_OK  = 6;
  localparam int HSWH_ST_SCHED_ERR = 7;
  localparam int HSWH_ST_NEGO      = 8;
  localparam int HSWH_ST_REQ_SYNC  = 9;

  // receive latency in milliseconds
  localparam logic [31:0] HSWH_LAT_DEFAULT_MS = 32'h0000_07d0; // 2000 ms
  localparam logic [31:0] HSWH_LAT_MIN_MS     = 32'h0000_07d0;

  // service period length in microseconds and in cycles at 25 MHz
  localparam int HSWH_CLK_MHZ    = 25;
  localparam int HSWH_SVC_US     = 100;
  localparam int HSWH_SVC_CYCLES = HSWH_SVC_US * HSWH_CLK_MHZ;

  localparam int HSWH_CMD_DEPTH = 4;
  localparam int HSWH_CMD_AW    = 2;

  typedef enum logic [1:0] {
    HSWH_MODE_ACTIVE  = 2'b00,
    HSWH_MODE_RET     = 2'b01,
    HSWH_MODE_NORET   = 2'b10,
    HSWH_MODE_SCHED   = 2'b11
  } hswh_mode_type;

  typedef enum logic [2:0] {
    HSWH_ST_SLEEP  = 3'b000,
    HSWH_ST_AWAKE  = 3'b001,
    HSWH_ST_SERVE  = 3'b010,
    HSWH_ST_RELEASE= 3'b011,
    HSWH_ST_SVCPER = 3'b100,
    HSWH_ST_ACTIVE = 3'b101
  } hswh_state_type;

endpackage : hswh_pkg

// ### hswh_ram.sv
`timescale 1ns/1ns
// small retained command store; read data registered
module hswh_ram
  import hswh_pkg::*;
(
  // clock
  input  wire logic                   hclk,
  // write port
  input  wire logic                   wr_en,
  input  wire logic [HSWH_CMD_AW-1:0] wr_addr,
  input  wire logic [31:0]            wr_data,
  // read port
  input  wire logic [HSWH_CMD_AW-1:0] rd_addr,
  output logic      [31:0]            rd_data_ff
);

  logic [31:0] mem [HSWH_CMD_DEPTH];

  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end

endmodule : hswh_ram

// ### hswh_checker.sv
`timescale 1ns/1ns
module hswh_checker
  import hswh_pkg::*;
(
  // bus side
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // handshake side
  input wire logic        lp_wake_request_pin,
  input wire logic        ulp_wake_request_pin,
  input wire logic        wake_indication_pin_a_ff,
  input wire logic        wake_indication_pin_b_ff,
  input wire logic        resp_valid_ff
);
  logic        wr_ctrl_ff, nxt_wr_ctrl, req, ind;
  logic [2:0]  ctrl_ff, nxt_ctrl;
  logic [11:0] cnt_ff, nxt_cnt;
  // shadow of mode and pin select, high-time counter cleared on mode writes
  always_comb begin
    ind         = wake_indication_pin_a_ff;
    req         = ctrl_ff[2] ? ulp_wake_request_pin : lp_wake_request_pin;
    nxt_wr_ctrl = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == HSWH_CTRL_OFS);
    nxt_ctrl    = wr_ctrl_ff ? hwdata[2:0] : ctrl_ff;
    nxt_cnt     = (ind & !wr_ctrl_ff) ? cnt_ff + 12'h001 : 12'h000;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_ff <= 1'b0;
      ctrl_ff    <= 3'h0;
      cnt_ff     <= 12'h000;
    end else begin
      wr_ctrl_ff <= nxt_wr_ctrl;
      ctrl_ff    <= nxt_ctrl;
      cnt_ff     <= nxt_cnt;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_PINS_MATCH:
    assert property (ind == wake_indication_pin_b_ff) else $error("pins differ");
  AST_NORET_QUIET:
    assert property (ctrl_ff[1:0] == HSWH_MODE_NORET |-> !resp_valid_ff)
    else $error("data sent in non-retained standby");
  AST_RESP_AWAKE:
    assert property (resp_valid_ff |-> ind) else $error("response while asleep");
  AST_RESP_SINGLE:
    assert property (resp_valid_ff |=> !resp_valid_ff) else $error("response pulse too long");
  AST_WAKE_RISE:
    assert property ((ctrl_ff[1] != ctrl_ff[0]) && $rose(req) && !ind |-> ##[1:5] ind)
    else $error("no wake indication");
  AST_FALL_GRANTED:
    assert property (ctrl_ff[1:0] == HSWH_MODE_RET && $fell(ind) |-> !req)
    else $error("slept without permission");
  AST_AWAKE_HOLD:
    assert property (ctrl_ff[1:0] == HSWH_MODE_RET && req && ind && !wr_ctrl_ff |=> ind)
    else $error("slept while request held");
  AST_SVC_LEN:
    assert property (ctrl_ff[1:0] == HSWH_MODE_SCHED && $fell(ind) && cnt_ff > 12'd16
      |-> cnt_ff == HSWH_SVC_CYCLES + 1) else $error("service period length wrong");
  COV_RESP: cover property (resp_valid_ff);
  COV_WAKE: cover property (ctrl_ff[1:0] == HSWH_MODE_RET && $rose(req));
  COV_SVC: cover property (ctrl_ff[1:0] == HSWH_MODE_SCHED && $fell(ind));
endmodule : hswh_checker

bind hswh_top hswh_checker u_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .lp_wake_request_pin(lp_wake_request_pin), .ulp_wake_request_pin(ulp_wake_request_pin),
  .wake_indication_pin_a_ff(wake_indication_pin_a_ff),
  .wake_indication_pin_b_ff(wake_indication_pin_b_ff), .resp_valid_ff(resp_valid_ff));

// ### hswh_host_model.sv
`timescale 1ns/1ns
module hswh_host_model (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // bench control
  input  wire logic want_wake,
  input  wire logic use_ulp,
  // device pins
  input  wire logic wake_ind,
  output logic      lp_wake_request_pin,
  output logic      ulp_wake_request_pin,
  output logic      host_awake
);
  logic req_ff, nxt_req;
  // dropping the request is the sleep permission
  always_comb nxt_req = want_wake;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
    end
  end
  assign lp_wake_request_pin  = req_ff & !use_ulp;
  assign ulp_wake_request_pin = req_ff & use_ulp;
  // commands only once the device shows it is awake
  assign host_awake = req_ff & wake_ind;
endmodule : hswh_host_model

// ### testbench.sv
`timescale 1ns/1ns
module testbench
  import hswh_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, want = 1'b0, ulp = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_ff, resp_data_ff, q;
  logic [1:0]  htrans = 2'b00;
  logic        hreadyout_ff, hresp_ff, lp_pin, ulp_pin, ind_a, ind_b, resp_valid_ff, awake;
  int          err_total = 0, check_count = 0, n, rsp_cnt = 0;
  always #20 hclk = ~hclk;
  always @(negedge hclk) if (resp_valid_ff === 1'b1) rsp_cnt++;
  hswh_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout_ff),
    .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .lp_wake_request_pin(lp_pin), .ulp_wake_request_pin(ulp_pin),
    .wake_indication_pin_a_ff(ind_a), .wake_indication_pin_b_ff(ind_b),
    .resp_valid_ff(resp_valid_ff), .resp_data_ff(resp_data_ff));
  hswh_host_model u_host (.hclk(hclk), .hresetn(hresetn), .want_wake(want), .use_ulp(ulp),
    .wake_ind(ind_a), .lp_wake_request_pin(lp_pin), .ulp_wake_request_pin(ulp_pin),
    .host_awake(awake));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    q = hrdata_ff;
  endtask : bus
  task automatic wait_ind(input logic v);
    n = 0;
    do begin @(negedge hclk); n++; end while (ind_a !== v && n < 4000);
    @(posedge hclk);
  endtask : wait_ind
  task automatic t_reset;
    chk("ind_b", 1'b1, ind_b);
    chk("hresp", 1'b0, hresp_ff);
    bus(0, HSWH_LAT_OFS, 0);
    chk("lat", 32'h7d0, q);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ret;
    for (int s = 0; s < 2; s++) begin
      bus(1, HSWH_CTRL_OFS, {29'h0, s[0], 2'b01});
      wait_ind(0);
      chk("asleep", 0, ind_a);
      ulp  <= ~s[0];
      want <= 1'b1;
      repeat (10) @(posedge hclk);
      chk("other pin", 0, ind_a);
      want <= 1'b0;
      repeat (4) @(posedge hclk);
      ulp  <= s[0];
      want <= 1'b1;
      wait_ind(1);
      chk("awake", 1, awake);
      bus(1, HSWH_CMD_OFS, 32'ha50 + s);
      bus(1, HSWH_RESP_OFS, 32'h5a00 + s);
      n = 0;
      while (resp_valid_ff !== 1'b1 && n < 8) begin @(negedge hclk); n++; end
      chk("resp", 32'h5a00 + s, resp_data_ff);
      @(posedge hclk);
      want <= 1'b0;
      wait_ind(0);
      chk("asleep again", 0, ind_a);
      bus(0, HSWH_CMD_OFS, 0);
      chk("cmd kept", 32'ha50 + s, q);
    end
    bus(1, HSWH_CTRL_OFS, 0);
    $display("test retained done");
  endtask : t_ret
  task automatic t_nret;
    int m;
    m = rsp_cnt;
    ulp <= 1'b0;
    bus(1, HSWH_CTRL_OFS, 2);
    wait_ind(0);
    chk("asleep", 0, ind_a);
    want <= 1'b1;
    wait_ind(1);
    chk("woken", 1, ind_a);
    bus(1, HSWH_CTRL_OFS, 0);
    want <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("active", 1, ind_a);
    chk("no data", m, rsp_cnt);
    $display("test non-retained done");
  endtask : t_nret
  task automatic t_sched;
    logic [31:0] ctl[5] = '{32'h0, 32'h18, 32'h8, 32'h8, 32'h8};
    logic [31:0] lat[5] = '{32'hbb8, 32'hbb8, 32'h7d0, 32'h7d1, 32'h0};
    logic [1:0]  res[5] = '{2'b10, 2'b10, 2'b10, 2'b01, 2'b10};
    for (int i = 0; i < 5; i++) begin
      bus(1, HSWH_CTRL_OFS, ctl[i]);
      bus(1, HSWH_LAT_OFS, lat[i]);
      bus(1, HSWH_STATUS_OFS, 32'hc0);
      bus(1, HSWH_SCHED_OFS, 1);
      bus(0, HSWH_STATUS_OFS, 0);
      chk("sched", res[i], q[7:6]);
    end
    bus(0, HSWH_LAT_OFS, 0);
    chk("lat zero", 32'h7d0, q);
    bus(1, HSWH_TPUT_OFS, 32'h00c8_0064);
    bus(0, HSWH_TPUT_OFS, 0);
    chk("tput", 32'h00c8_0064, q);
    $display("test schedule done");
  endtask : t_sched
  task automatic t_svc;
    bus(1, HSWH_CTRL_OFS, 3);
    wait_ind(0);
    chk("asleep", 0, ind_a);
    bus(1, HSWH_CTRL_OFS, 32'h23);
    wait_ind(1);
    chk("svc wake", 1, ind_a);
    wait_ind(0);
    chk("svc cycles", HSWH_SVC_CYCLES + 1, n);
    $display("test service period done");
  endtask : t_svc
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_reset;
    t_ret;
    t_nret;
    t_sched;
    t_svc;
    summarize;
  end
  initial begin
    #(40 * 20000);
    err_total++;
    summarize;
  end
endmodule : testbench
